/* File: acsc_map.svh */
// Register offsets, field positions, reset values and timing counts
// for the serial channel control block. Definitions only.
`ifndef ACSC_MAP_SVH
`define ACSC_MAP_SVH
`define ACSC_OFS_CTRL 6'h20
`define ACSC_OFS_COUNT_A 6'h24
`define ACSC_OFS_COUNT_B 6'h28
`define ACSC_OFS_COUNT_R 6'h2C
`define ACSC_CTRL_RESET 32'hFF800000
`define ACSC_CTRL_ONES 32'hFF800000
`define ACSC_COUNT_RESET 16'h0000
`define ACSC_BIT_TEST_SRC 22
`define ACSC_END_STEP_LO 19
`define ACSC_START_STEP_LO 16
`define ACSC_BIT_REC_STOP 15
`define ACSC_BIT_B_STOP 14
`define ACSC_BIT_A_STOP 13
`define ACSC_BIT_B_HOLD 12
`define ACSC_BIT_A_HOLD 11
`define ACSC_BIT_REC_IRQ 10
`define ACSC_BIT_B_IRQ 9
`define ACSC_BIT_A_IRQ 8
`define ACSC_BIT_A_RELOAD 7
`define ACSC_BIT_B_HOLD_OFF 6
`define ACSC_BIT_REC_16 5
`define ACSC_BIT_REC_STEREO 4
`define ACSC_CLK_NS 20
`define ACSC_RELOAD_HOLD_NS 1000
`define ACSC_RELOAD_HOLD_CYC (`ACSC_RELOAD_HOLD_NS / `ACSC_CLK_NS)
`endif

/* File: acsc_pkg.sv */
// Types shared by the serial channel control block.
// Assumes acsc_map.svh supplies the numeric constants.
package acsc_pkg;
    // Channel sequencer, Gray coded along idle, run, stop
    typedef enum logic [1:0] {
        ACSC_IDLE = 2'b00,
        ACSC_RUN = 2'b01,
        ACSC_STOP = 2'b11
    } acsc_state_e;
    // Sample formats: bit 1 sixteen bit, bit 0 stereo
    typedef enum logic [1:0] {
        ACSC_FMT_8M = 2'b00,
        ACSC_FMT_8S = 2'b01,
        ACSC_FMT_16M = 2'b10,
        ACSC_FMT_16S = 2'b11
    } acsc_fmt_e;
endpackage

/* File: acsc_channel.sv */
// One sample channel: live sample counter, loop/stop sequencing and
// the pending interrupt flag. Assumes tick_i is a one-cycle frame pulse.
`timescale 1ns/1ps
`default_nettype none
module acsc_channel (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Control
    input wire logic enable_i,
    input wire logic tick_i,
    input wire logic hold_i,
    input wire logic stop_on_zero_i,
    input wire logic irq_enable_i,
    input wire logic load_req_i,
    input wire logic [15:0] count_i,
    // Status
    output logic [15:0] live_o,
    output logic advance_o,
    output logic start_o,
    output logic wrap_o,
    output logic stopped_o,
    output logic irq_o
);
    import acsc_pkg::*;
    acsc_state_e state_r, state_nxt;
    logic [15:0] live_r, live_nxt;
    logic irq_r, irq_nxt;
    logic load_r, load_nxt;

    // Sequencer; a pending forced load takes the next frame instead of a sample
    always_comb begin
        state_nxt = state_r;
        live_nxt = live_r;
        irq_nxt = irq_r & irq_enable_i; // R10
        load_nxt = load_r | load_req_i;
        start_o = 1'b0;
        advance_o = 1'b0;
        wrap_o = 1'b0;
        if (!enable_i) begin
            state_nxt = ACSC_IDLE;
        end else begin
            unique case (state_r)
                ACSC_IDLE: begin
                    state_nxt = ACSC_RUN;
                    live_nxt = count_i; // R17
                    load_nxt = 1'b0;
                    start_o = 1'b1;
                end
                ACSC_RUN, ACSC_STOP: begin
                    if (tick_i && load_r) begin
                        live_nxt = count_i; // R11
                        load_nxt = load_req_i;
                    end else if (tick_i && state_r == ACSC_RUN && !hold_i) begin
                        advance_o = 1'b1; // R19
                        if (live_r == 16'h0000) begin
                            wrap_o = 1'b1;
                            irq_nxt = irq_enable_i; // R7 R8 R10
                            if (stop_on_zero_i) begin
                                state_nxt = ACSC_STOP; // R7 R8
                            end else begin
                                live_nxt = count_i; // R19
                            end
                        end else begin
                            live_nxt = live_r - 16'h0001; // R19
                        end
                    end
                end
                default: state_nxt = ACSC_IDLE;
            endcase
        end
    end

    // State registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= ACSC_IDLE;
            live_r <= 16'h0000;
            irq_r <= 1'b0;
            load_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            live_r <= live_nxt;
            irq_r <= irq_nxt;
            load_r <= load_nxt;
        end
    end

    assign live_o = live_r;
    assign stopped_o = (state_r == ACSC_STOP);
    assign irq_o = irq_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    irq_clear_a: assert property (!irq_enable_i |=> !irq_o) // R10
        else $error("pending interrupt survived a zero enable");
    loop_reload_a: assert property (wrap_o && !stop_on_zero_i |=> live_o == $past(count_i)) // R19
        else $error("loop mode did not reload the counter");
    stop_entry_a: assert property (wrap_o && stop_on_zero_i && enable_i |=> stopped_o) // R7
        else $error("stop mode did not stop at zero");
    count_step_a: assert property (advance_o && live_o != 16'h0000 |=> live_o == $past(live_o) - 16'h0001) // R19
        else $error("counter did not step down by one");
endmodule
`default_nettype wire

/* File: acsc_serial_ctrl.sv */
// Serial channel control: control and count registers, frame timing
// from the codec or test clock, and the sample format paths.
// Assumes a host register port on clk_i and frame clocks from pins.
//
// Summary of operation
// [R1] Control bits 31..23 read as ones; writes to them have no effect.
// [R2] Test bit 22 takes frame timing from the serial input word clock.
// [R3] In loop mode, channel B adds its end step at each loop end.
// [R4] Software keeps the loop end step nonzero: one for 8-bit, two 16-bit.
// [R5] Each start of channel B adds its start step to the address.
// [R6] Software programs an even start step for 16-bit channel B samples.
// [R7] Record count zero raises interrupt if enabled; bit 15 stops recording.
// [R8] Playback count zero raises interrupt; stop bit set holds last sample.
// [R9] Playback hold bit repeats the last sample from the next sample on.
// [R10] Interrupt enable gates interrupt; writing zero clears it, one re-arms.
// [R11] Rising reload bit loads channel A count at next frame clock edge.
// [R12] Software may drop the reload bit at once; under one microsecond suffices.
// [R13] Disabled channel B sends zeros, or last sample with bit 6 and stop.
// [R14] Record format: 8-bit mono, 8-bit stereo, 16-bit mono, 16-bit stereo.
// [R15] Eight-bit record inverts sample msb; mono record keeps left only.
// [R16] Count registers: low 16 bits writable, high 16 bits show live count.
// [R17] Programmed count holds the number of samples minus one.
// [R18] Eight-bit playback inverts msb; mono playback sends left to both.
// [R19] Live counter steps per frame and reloads at zero in loop mode.
`timescale 1ns/1ps
`default_nettype none
`include "acsc_map.svh"
module acsc_serial_ctrl (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Host register port
    input wire logic reg_wr_i,
    input wire logic [5:0] reg_addr_i,
    input wire logic [3:0] reg_be_i,
    input wire logic [31:0] reg_wdata_i,
    output logic [31:0] reg_rdata_o,
    // Frame clocks from pins
    input wire logic codec_lrclk_i,
    input wire logic i2s_lrclk_i,
    // Channel enables and playback formats
    input wire logic play_a_enable_i,
    input wire logic play_b_enable_i,
    input wire logic rec_enable_i,
    input wire acsc_pkg::acsc_fmt_e play_a_format_i,
    input wire acsc_pkg::acsc_fmt_e play_b_format_i,
    // Playback sample words from the cache
    input wire logic [31:0] play_a_word_i,
    input wire logic [31:0] play_b_word_i,
    output logic play_a_fetch_o,
    output logic play_b_fetch_o,
    output logic [15:0] play_b_addr_o,
    // Playback samples to the codec
    output logic [15:0] play_a_left_o,
    output logic [15:0] play_a_right_o,
    output logic [15:0] play_b_left_o,
    output logic [15:0] play_b_right_o,
    // Record samples from the codec, words to the cache
    input wire logic [15:0] rec_left_i,
    input wire logic [15:0] rec_right_i,
    output logic [31:0] rec_word_o,
    output logic rec_valid_o,
    // Pending channel interrupts
    output logic play_a_irq_o,
    output logic play_b_irq_o,
    output logic rec_irq_o
);
    import acsc_pkg::*;

    logic [22:0] ctrl_r, ctrl_nxt;
    logic [15:0] cnt_a_r, cnt_a_nxt, cnt_b_r, cnt_b_nxt, cnt_r_r, cnt_r_nxt;
    logic [1:0] codec_sync_r, i2s_sync_r;
    logic frame_prev_r, rld_prev_r;
    logic [31:0] rdata_nxt;
    logic frame_lvl, tick, reload_rise;
    logic [15:0] live_a, live_b, live_rec;
    logic start_b, wrap_b, wrap_a, wrap_rec, rec_adv, stopped_a, stopped_b;
    logic stopped_rec;
    logic [15:0] addr_b_r, addr_b_nxt;
    logic [15:0] pa_l_r, pa_l_nxt, pa_r_r, pa_r_nxt, pb_l_r, pb_l_nxt, pb_r_r, pb_r_nxt;
    logic [31:0] rec_word_r, rec_word_nxt;
    logic rec_valid_r, rec_valid_nxt;

    // Byte-lane merge for partial writes
    function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Playback word to left/right pair; 8-bit data is unsigned, so its msb flips
    function automatic logic [31:0] play_decode(input acsc_fmt_e fmt, input logic [31:0] w);
        logic [15:0] l, r;
        l = w[15:0];
        r = w[31:16];
        unique case (fmt)
            ACSC_FMT_8M: begin
                l = {~w[7], w[6:0], 8'h00}; // R18
                r = l;
            end
            ACSC_FMT_8S: begin
                l = {~w[7], w[6:0], 8'h00}; // R18
                r = {~w[15], w[14:8], 8'h00};
            end
            ACSC_FMT_16M: r = l; // R18
            ACSC_FMT_16S: r = w[31:16];
        endcase
        return {r, l};
    endfunction

    // Bytes taken per sample frame by channel B
    function automatic logic [15:0] frame_bytes(input acsc_fmt_e fmt);
        unique case (fmt)
            ACSC_FMT_8M: frame_bytes = 16'h0001;
            ACSC_FMT_8S, ACSC_FMT_16M: frame_bytes = 16'h0002;
            ACSC_FMT_16S: frame_bytes = 16'h0004;
        endcase
    endfunction

    // Pin synchronisers; only the second stage is read
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            codec_sync_r <= 2'b00;
            i2s_sync_r <= 2'b00;
        end else begin
            codec_sync_r <= {codec_sync_r[0], codec_lrclk_i};
            i2s_sync_r <= {i2s_sync_r[0], i2s_lrclk_i};
        end
    end

    // Frame source select and rising-edge tick
    assign frame_lvl = ctrl_r[`ACSC_BIT_TEST_SRC] ? i2s_sync_r[1] : codec_sync_r[1]; // R2
    assign tick = frame_lvl & ~frame_prev_r;
    assign reload_rise = ctrl_r[`ACSC_BIT_A_RELOAD] & ~rld_prev_r; // R11 R12

    // Register writes and read data
    always_comb begin
        logic [31:0] m;
        m = merge_be({9'h000, ctrl_r}, reg_wdata_i, reg_be_i);
        ctrl_nxt = ctrl_r;
        cnt_a_nxt = cnt_a_r;
        cnt_b_nxt = cnt_b_r;
        cnt_r_nxt = cnt_r_r;
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                `ACSC_OFS_CTRL: ctrl_nxt = m[22:0]; // R1
                `ACSC_OFS_COUNT_A: cnt_a_nxt = merge_be({16'h0000, cnt_a_r}, reg_wdata_i, reg_be_i)
                                               [15:0]; // R16
                `ACSC_OFS_COUNT_B: cnt_b_nxt = merge_be({16'h0000, cnt_b_r}, reg_wdata_i, reg_be_i)
                                               [15:0]; // R16
                `ACSC_OFS_COUNT_R: cnt_r_nxt = merge_be({16'h0000, cnt_r_r}, reg_wdata_i, reg_be_i)
                                               [15:0]; // R16
                default: ;
            endcase
        end
        unique case (reg_addr_i)
            `ACSC_OFS_CTRL: rdata_nxt = `ACSC_CTRL_ONES | {9'h000, ctrl_r}; // R1
            `ACSC_OFS_COUNT_A: rdata_nxt = {live_a, cnt_a_r}; // R16
            `ACSC_OFS_COUNT_B: rdata_nxt = {live_b, cnt_b_r}; // R16
            `ACSC_OFS_COUNT_R: rdata_nxt = {live_rec, cnt_r_r}; // R16
            default: rdata_nxt = 32'h00000000;
        endcase
    end

    // Register file and edge history
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_r <= 23'(`ACSC_CTRL_RESET);
            cnt_a_r <= `ACSC_COUNT_RESET;
            cnt_b_r <= `ACSC_COUNT_RESET;
            cnt_r_r <= `ACSC_COUNT_RESET;
            reg_rdata_o <= 32'h00000000;
            frame_prev_r <= 1'b0;
            rld_prev_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            cnt_a_r <= cnt_a_nxt;
            cnt_b_r <= cnt_b_nxt;
            cnt_r_r <= cnt_r_nxt;
            reg_rdata_o <= rdata_nxt;
            frame_prev_r <= frame_lvl;
            rld_prev_r <= ctrl_r[`ACSC_BIT_A_RELOAD];
        end
    end

    // Channel A playback sequencer
    acsc_channel u_play_a (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .enable_i(play_a_enable_i),
        .tick_i(tick),
        .hold_i(ctrl_r[`ACSC_BIT_A_HOLD]), // R9
        .stop_on_zero_i(ctrl_r[`ACSC_BIT_A_STOP]),
        .irq_enable_i(ctrl_r[`ACSC_BIT_A_IRQ]),
        .load_req_i(reload_rise), // R11
        .count_i(cnt_a_r),
        .live_o(live_a),
        .advance_o(play_a_fetch_o),
        .start_o(),
        .wrap_o(wrap_a),
        .stopped_o(stopped_a),
        .irq_o(play_a_irq_o)
    );

    // Channel B playback sequencer
    acsc_channel u_play_b (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .enable_i(play_b_enable_i),
        .tick_i(tick),
        .hold_i(ctrl_r[`ACSC_BIT_B_HOLD]), // R9
        .stop_on_zero_i(ctrl_r[`ACSC_BIT_B_STOP]),
        .irq_enable_i(ctrl_r[`ACSC_BIT_B_IRQ]),
        .load_req_i(1'b0),
        .count_i(cnt_b_r),
        .live_o(live_b),
        .advance_o(play_b_fetch_o),
        .start_o(start_b),
        .wrap_o(wrap_b),
        .stopped_o(stopped_b),
        .irq_o(play_b_irq_o)
    );

    // Record sequencer; no hold control on this channel
    acsc_channel u_rec (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .enable_i(rec_enable_i),
        .tick_i(tick),
        .hold_i(1'b0),
        .stop_on_zero_i(ctrl_r[`ACSC_BIT_REC_STOP]),
        .irq_enable_i(ctrl_r[`ACSC_BIT_REC_IRQ]),
        .load_req_i(1'b0),
        .count_i(cnt_r_r),
        .live_o(live_rec),
        .advance_o(rec_adv),
        .start_o(),
        .wrap_o(wrap_rec),
        .stopped_o(stopped_rec),
        .irq_o(rec_irq_o)
    );

    // Sample paths; a held or stopped channel keeps its last pair by not loading
    always_comb begin
        logic [31:0] da, db;
        da = play_decode(play_a_format_i, play_a_word_i);
        db = play_decode(play_b_format_i, play_b_word_i);
        {pa_r_nxt, pa_l_nxt} = play_a_fetch_o ? da : {pa_r_r, pa_l_r}; // R8 R9
        {pb_r_nxt, pb_l_nxt} = play_b_fetch_o ? db : {pb_r_r, pb_l_r}; // R8 R9
        if (!play_b_enable_i && !(ctrl_r[`ACSC_BIT_B_HOLD_OFF] && ctrl_r[`ACSC_BIT_B_STOP])) begin
            {pb_r_nxt, pb_l_nxt} = 32'h00000000; // R13
        end
        addr_b_nxt = addr_b_r;
        if (start_b) begin
            addr_b_nxt = addr_b_r + {13'h0000, ctrl_r[`ACSC_START_STEP_LO +: 3]}; // R5
        end else if (play_b_fetch_o) begin
            addr_b_nxt = addr_b_r + frame_bytes(play_b_format_i);
            if (wrap_b && !ctrl_r[`ACSC_BIT_B_STOP]) begin
                addr_b_nxt = addr_b_r + {13'h0000, ctrl_r[`ACSC_END_STEP_LO +: 3]}; // R3
            end
        end
        rec_valid_nxt = rec_adv;
        rec_word_nxt = rec_word_r;
        if (rec_adv) begin
            unique case (ctrl_r[`ACSC_BIT_REC_16 -: 2]) // R14
                ACSC_FMT_8M: rec_word_nxt = {24'h000000, ~rec_left_i[15], rec_left_i[14:8]}; // R15
                ACSC_FMT_8S: rec_word_nxt = {16'h0000, ~rec_right_i[15], rec_right_i[14:8],
                                             ~rec_left_i[15], rec_left_i[14:8]}; // R15
                ACSC_FMT_16M: rec_word_nxt = {16'h0000, rec_left_i}; // R15
                ACSC_FMT_16S: rec_word_nxt = {rec_right_i, rec_left_i};
            endcase
        end
    end

    // Sample path registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pa_l_r <= 16'h0000;
            pa_r_r <= 16'h0000;
            pb_l_r <= 16'h0000;
            pb_r_r <= 16'h0000;
            addr_b_r <= 16'h0000;
            rec_word_r <= 32'h00000000;
            rec_valid_r <= 1'b0;
        end else begin
            pa_l_r <= pa_l_nxt;
            pa_r_r <= pa_r_nxt;
            pb_l_r <= pb_l_nxt;
            pb_r_r <= pb_r_nxt;
            addr_b_r <= addr_b_nxt;
            rec_word_r <= rec_word_nxt;
            rec_valid_r <= rec_valid_nxt;
        end
    end

    assign play_a_left_o = pa_l_r;
    assign play_a_right_o = pa_r_r;
    assign play_b_left_o = pb_l_r;
    assign play_b_right_o = pb_r_r;
    assign play_b_addr_o = addr_b_r;
    assign rec_word_o = rec_word_r;
    assign rec_valid_o = rec_valid_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    ones_read_a: assert property (reg_addr_i == `ACSC_OFS_CTRL |=> reg_rdata_o[31:23] == 9'h1FF) // R1
        else $error("control top bits did not read as ones");
    test_source_a: assert property (ctrl_r[`ACSC_BIT_TEST_SRC] && i2s_sync_r[1] && !frame_prev_r
                                    |-> tick) // R2
        else $error("test clock edge gave no frame tick");
    reload_load_a: assert property (first_match(reload_rise && play_a_enable_i && !stopped_a
                                    ##[1:300] (tick && play_a_enable_i)) |=> live_a == $past(cnt_a_r)) // R11
        else $error("reload did not load channel A count");
    off_zero_a: assert property (!play_b_enable_i && !ctrl_r[`ACSC_BIT_B_HOLD_OFF]
                                 |=> play_b_left_o == 16'h0000 && play_b_right_o == 16'h0000) // R13
        else $error("disabled channel B was not silent");
    hold_keep_a: assert property (ctrl_r[`ACSC_BIT_A_HOLD]
                                  |=> $stable(play_a_left_o) && $stable(play_a_right_o)) // R9
        else $error("held channel A fetched a new sample");
    rec_mono8_a: assert property (rec_adv && ctrl_r[5:4] == 2'b00
                                  |=> rec_valid_o && rec_word_o[7] == !$past(rec_left_i[15])) // R15
        else $error("8-bit record msb not inverted");
    start_step_a: assert property (start_b |=> play_b_addr_o == $past(addr_b_r)
                                   + {13'h0000, $past(ctrl_r[18:16])}) // R5
        else $error("start step not added");
endmodule
`default_nettype wire

/* File: acsc_codec_model.sv */
// Codec side of the link: frame clock bursts and record samples.
// Assumes run_i comes from the bench clock and is held for whole frames.
`timescale 1ns/1ps
`default_nettype none
module acsc_codec_model #(
    parameter logic [15:0] LEFT = 16'hA5A5,
    parameter logic [15:0] RIGHT = 16'h3C3C
) (
    // Burst control
    input wire logic run_i,
    // Link outputs
    output logic lrclk_o,
    output logic [15:0] rec_left_o,
    output logic [15:0] rec_right_o
);
    // Clock stands still low between bursts; odd delays keep its rising edges
    // off the system clock edges, one rising edge per 160 ns frame
    initial begin
        lrclk_o = 1'b0;
        forever begin
            wait (run_i === 1'b1);
            #87 lrclk_o = 1'b1;
            #73 lrclk_o = 1'b0;
        end
    end
    // Both bytes of a sample match, so an 8-bit record sees one value
    assign rec_left_o = LEFT;
    assign rec_right_o = RIGHT;
endmodule
`default_nettype wire

/* File: acsc_serial_ctrl_tb.sv */
// Self-checking bench for the serial channel control block.
// Assumes the codec model in acsc_codec_model.sv for both frame clocks.
`timescale 1ns/1ps
`default_nettype none
module acsc_serial_ctrl_tb;
    import acsc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0;
    logic [5:0] addr = 6'h00;
    logic [3:0] be = 4'hF;
    logic [31:0] wdata = 32'h00000000;
    logic run_c = 1'b0;
    logic run_s = 1'b0;
    logic en_a = 1'b0;
    logic en_b = 1'b0;
    logic en_r = 1'b0;
    acsc_fmt_e fmt_a = ACSC_FMT_16S;
    acsc_fmt_e fmt_b = ACSC_FMT_16M;
    logic [31:0] word_a = 32'h12345678;
    logic [31:0] word_b = 32'hAAAA5555;
    logic [31:0] rdata, rw, rword, got;
    logic lr_c, lr_s, fa, fb, rv, irq_a, irq_b, irq_r;
    logic [15:0] addr_b, la, ra, lb, rb, rl, rr;
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;
    int nfa, nfb, nrv;
    // Expected record words and the bytes each format defines
    localparam logic [31:0] REC_EXP [4] = '{32'h00000025, 32'h0000BC25, 32'h0000A5A5, 32'h3C3CA5A5};
    localparam logic [31:0] REC_MSK [4] = '{32'h000000FF, 32'h0000FFFF, 32'h0000FFFF, 32'hFFFFFFFF};

    acsc_serial_ctrl dut (
        .clk_i(clk), .rst_n_i(rst_n), .reg_wr_i(wr), .reg_addr_i(addr), .reg_be_i(be),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .codec_lrclk_i(lr_c), .i2s_lrclk_i(lr_s),
        .play_a_enable_i(en_a), .play_b_enable_i(en_b), .rec_enable_i(en_r),
        .play_a_format_i(fmt_a), .play_b_format_i(fmt_b), .play_a_word_i(word_a),
        .play_b_word_i(word_b), .play_a_fetch_o(fa), .play_b_fetch_o(fb), .play_b_addr_o(addr_b),
        .play_a_left_o(la), .play_a_right_o(ra), .play_b_left_o(lb), .play_b_right_o(rb),
        .rec_left_i(rl), .rec_right_i(rr), .rec_word_o(rw), .rec_valid_o(rv),
        .play_a_irq_o(irq_a), .play_b_irq_o(irq_b), .rec_irq_o(irq_r)
    );
    // Codec frame clock with record data, and a separate word clock source
    acsc_codec_model codec (.run_i(run_c), .lrclk_o(lr_c), .rec_left_o(rl), .rec_right_o(rr));
    acsc_codec_model wordclk (.run_i(run_s), .lrclk_o(lr_s), .rec_left_o(), .rec_right_o());

    always #10 clk = ~clk;

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // One-cycle write strobe; released at the next edge
    task automatic wreg(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data is registered, so it is taken two cycles after the address is set
    task automatic rreg(input logic [5:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        repeat (2) @(posedge clk);
        #1 d = rdata;
    endtask

    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask

    // Run n frames from one source and count fetches and record words;
    // the burst ends a cycle early so no extra frame edge slips out
    task automatic frames(input int n, input bit word_src);
        nfa = 0;
        nfb = 0;
        nrv = 0;
        @(posedge clk);
        if (word_src) run_s <= 1'b1;
        else run_c <= 1'b1;
        for (int k = 0; k < n * 8 + 8; k++) begin
            @(posedge clk);
            if (k == n * 8 - 2) begin
                run_c <= 1'b0;
                run_s <= 1'b0;
            end
            #1;
            nfa += int'(fa);
            nfb += int'(fb);
            nrv += int'(rv);
            if (rv === 1'b1) rword = rw;
        end
    endtask

    task automatic report_and_stop;
        if (err_total == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // A hang is cut short well past the expected run length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_total++;
            report_and_stop();
        end
    end

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        // Control register top bits and unmapped space
        rreg(6'h20, got);
        chk("ctrl reset", 32'hFF800000, got);
        wreg(6'h20, 32'hFFFFFFFF);
        rreg(6'h20, got);
        chk("ctrl all set", 32'hFFFFFFFF, got);
        wreg(6'h20, 32'h00000000);
        rreg(6'h20, got);
        chk("ctrl cleared", 32'hFF800000, got);
        rreg(6'h30, got);
        chk("unmapped", 32'h00000000, got);
        wreg(6'h24, 32'hFFFF0005);
        rreg(6'h24, got);
        chk("count a", 32'h00000005, got);
        // Channel A stop mode, two samples, stereo pairing
        wreg(6'h20, 32'h00002100);
        wreg(6'h24, 32'h00000001);
        @(posedge clk) en_a <= 1'b1;
        frames(4, 1'b0);
        chk("fetches a", 32'd2, 32'(nfa));
        chk("irq a", 32'h1, {31'h0, irq_a});
        chk("left a", 32'h5678, {16'h0, la});
        chk("right a", 32'h1234, {16'h0, ra});
        rreg(6'h24, got);
        chk("live a", 32'h00000001, got);
        wreg(6'h20, 32'h00002000);
        settle();
        chk("irq a cleared", 32'h0, {31'h0, irq_a});
        // Channel B loop mode with start and end steps, mono copy
        wreg(6'h20, 32'h00220200);
        wreg(6'h28, 32'h00000001);
        @(posedge clk) en_b <= 1'b1;
        settle();
        chk("addr b start", 32'h2, {16'h0, addr_b});
        frames(5, 1'b0);
        chk("fetches b", 32'd5, 32'(nfb));
        chk("addr b loop", 32'h10, {16'h0, addr_b});
        chk("irq b", 32'h1, {31'h0, irq_b});
        chk("left b", 32'h5555, {16'h0, lb});
        chk("right b", 32'h5555, {16'h0, rb});
        @(posedge clk) en_b <= 1'b0;
        settle();
        chk("left b off", 32'h0, {16'h0, lb});
        // Channel B stopped then disabled with hold-when-off set
        wreg(6'h20, 32'h00004040);
        wreg(6'h28, 32'h00000000);
        @(posedge clk) en_b <= 1'b1;
        fmt_b <= ACSC_FMT_8M;
        frames(2, 1'b0);
        chk("fetches b stop", 32'd1, 32'(nfb));
        @(posedge clk) en_b <= 1'b0;
        settle();
        chk("left b held", 32'hD500, {16'h0, lb});
        // Channel A hold, then resume
        wreg(6'h24, 32'h00000100);
        @(posedge clk) en_a <= 1'b0;
        @(posedge clk) en_a <= 1'b1;
        fmt_a <= ACSC_FMT_8S;
        wreg(6'h20, 32'h00000800);
        frames(3, 1'b0);
        chk("fetches a held", 32'd0, 32'(nfa));
        wreg(6'h20, 32'h00000000);
        frames(3, 1'b0);
        chk("fetches a resumed", 32'd3, 32'(nfa));
        chk("left a 8-bit", 32'hF800, {16'h0, la});
        chk("right a 8-bit", 32'hD600, {16'h0, ra});
        // Reload pulse dropped at once, taken on the next frame
        wreg(6'h20, 32'h00000080);
        wreg(6'h20, 32'h00000000);
        frames(1, 1'b0);
        chk("fetches a reload", 32'd0, 32'(nfa));
        rreg(6'h24, got);
        chk("live a reload", 32'h01000100, got);
        // Test source: word clock replaces codec frame clock
        wreg(6'h20, 32'h00400000);
        frames(2, 1'b0);
        chk("fetches codec", 32'd0, 32'(nfa));
        frames(2, 1'b1);
        chk("fetches word clk", 32'd2, 32'(nfa));
        // Record formats, every code
        wreg(6'h2C, 32'h0000FFFF);
        @(posedge clk) en_r <= 1'b1;
        for (int f = 0; f < 4; f++) begin
            wreg(6'h20, 32'(f) << 4);
            frames(1, 1'b0);
            chk("rec words", 32'd1, 32'(nrv));
            chk("rec word", REC_EXP[f], rword & REC_MSK[f]);
        end
        // Record stop mode with interrupt
        @(posedge clk) en_r <= 1'b0;
        wreg(6'h2C, 32'h00000000);
        wreg(6'h20, 32'h00008400);
        @(posedge clk) en_r <= 1'b1;
        frames(3, 1'b0);
        chk("rec words stop", 32'd1, 32'(nrv));
        chk("irq rec", 32'h1, {31'h0, irq_r});
        report_and_stop();
    end
endmodule
`default_nettype wire
